// >>> src/ifsb_pkg.sv
// Constants for the interrupt flag status bank: register map, implemented
// bit masks, flag positions and status bits.
// Assumes one clock domain and a plain address/strobe register port.
`default_nettype none

package ifsb_pkg;

  // Register port geometry
  localparam int          IFSB_ADDR_W    = 4;
  localparam int          IFSB_DATA_W    = 16;
  localparam int          IFSB_NUM_REGS  = 4;

  // Register map (word addresses on the plain port)
  localparam logic [3:0]  IFSB_ADDR_FLAG1 = 4'h0;
  localparam logic [3:0]  IFSB_ADDR_FLAG2 = 4'h1;
  localparam logic [3:0]  IFSB_ADDR_FLAG3 = 4'h2;
  localparam logic [3:0]  IFSB_ADDR_FLAG4 = 4'h3;
  localparam logic [3:0]  IFSB_ADDR_EN1   = 4'h4;
  localparam logic [3:0]  IFSB_ADDR_EN4   = 4'h7;
  localparam logic [3:0]  IFSB_ADDR_STAT  = 4'h8;
  localparam logic [3:0]  IFSB_ADDR_MASK  = 4'h9;

  // Reset values
  localparam logic [15:0] IFSB_FLAG_RST   = 16'h0000;
  localparam logic [15:0] IFSB_EN_RST     = 16'h0000;
  localparam logic [1:0]  IFSB_STAT_RST   = 2'h0;
  localparam logic [1:0]  IFSB_MASK_RST   = 2'h0;

  // Implemented flag positions per register, index 0 is register one
  localparam logic [15:0] IFSB_IMPL1 = 16'hfe1f;
  localparam logic [15:0] IFSB_IMPL2 = 16'h22e3;
  localparam logic [15:0] IFSB_IMPL3 = 16'h4006;
  localparam logic [15:0] IFSB_IMPL4 = 16'h010e;

  // Flag positions, register one
  localparam int IFSB_UART_B_TX_POS     = 15;
  localparam int IFSB_UART_B_RX_POS     = 14;
  localparam int IFSB_EXT_IRQ_B_POS     = 13;
  localparam int IFSB_TIMER_FIVE_POS    = 12;
  localparam int IFSB_TIMER_FOUR_POS    = 11;
  localparam int IFSB_COMPARE_FOUR_POS  = 10;
  localparam int IFSB_COMPARE_THREE_POS = 9;
  localparam int IFSB_EXT_IRQ_A_POS     = 4;
  localparam int IFSB_PIN_CHANGE_POS    = 3;
  localparam int IFSB_COMPARATOR_POS    = 2;
  localparam int IFSB_I2C_A_MASTER_POS  = 1;
  localparam int IFSB_I2C_A_SLAVE_POS   = 0;
  // Register two
  localparam int IFSB_PARALLEL_PORT_POS = 13;
  localparam int IFSB_COMPARE_FIVE_POS  = 9;
  localparam int IFSB_CAPTURE_FIVE_POS  = 7;
  localparam int IFSB_CAPTURE_FOUR_POS  = 6;
  localparam int IFSB_CAPTURE_THREE_POS = 5;
  localparam int IFSB_SPI_B_EVENT_POS   = 1;
  localparam int IFSB_SPI_B_FAULT_POS   = 0;
  // Register three
  localparam int IFSB_CALENDAR_POS      = 14;
  localparam int IFSB_I2C_B_MASTER_POS  = 2;
  localparam int IFSB_I2C_B_SLAVE_POS   = 1;
  // Register four
  localparam int IFSB_LOW_VOLTAGE_POS   = 8;
  localparam int IFSB_CHECKSUM_GEN_POS  = 3;
  localparam int IFSB_UART_B_ERROR_POS  = 2;
  localparam int IFSB_UART_A_ERROR_POS  = 1;

  // Block status bits (sticky, write one to clear)
  localparam int IFSB_STAT_NEW_POS      = 0;
  localparam int IFSB_STAT_OVR_POS      = 1;

endpackage

`default_nettype wire

// >>> src/ifsb_bank.sv
// Interrupt flag status bank: four 16-bit pending-flag registers, their
// enable registers, a request line to the CPU and a block interrupt.
// Assumes peripheral events are one-cycle pulses on clk_sys and that the
// register master follows the plain strobe protocol.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none

module ifsb_bank
  import ifsb_pkg::*;
(
  input  wire logic        clk_sys,   // System clock, 100 MHz
  input  wire logic        rstn,      // Synchronous reset, active low
  input  wire logic [3:0]  addr,      // Register word address
  input  wire logic [15:0] wdata,     // Write data
  input  wire logic        wr_en,     // Write strobe, one cycle
  input  wire logic        rd_en,     // Read strobe, one cycle
  output logic      [15:0] rdata,     // Read data, cycle after rd_en
  input  wire logic [15:0] evt_one,   // Event pulses, register one
  input  wire logic [15:0] evt_two,   // Event pulses, register two
  input  wire logic [15:0] evt_three, // Event pulses, register three
  input  wire logic [15:0] evt_four,  // Event pulses, register four
  output logic             cpu_req,   // Enabled flag pending, level
  output logic             irq        // Block interrupt, level
);

  // Flag, enable and event arrays, index 0 is register one
  logic [15:0] flag_r   [IFSB_NUM_REGS];
  logic [15:0] flag_nxt [IFSB_NUM_REGS];
  logic [15:0] en_r     [IFSB_NUM_REGS];
  logic [15:0] evt      [IFSB_NUM_REGS];
  logic [15:0] impl     [IFSB_NUM_REGS];
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  mask_r;
  logic [3:0]  new_hit;
  logic [3:0]  ovr_hit;
  logic [3:0]  req_hit;

  // Masks and event vectors in array form for the loop below
  assign impl[0] = IFSB_IMPL1;
  assign impl[1] = IFSB_IMPL2;
  assign impl[2] = IFSB_IMPL3;
  assign impl[3] = IFSB_IMPL4;
  assign evt[0]  = evt_one;
  assign evt[1]  = evt_two;
  assign evt[2]  = evt_three;
  assign evt[3]  = evt_four;

  // One flag and one enable register per bank slot
  for (genvar i = 0; i < IFSB_NUM_REGS; i++) begin : g_bank
    // Set beats clear: an event in the write cycle still lands
    always_comb begin
      flag_nxt[i] = flag_r[i];
      if (wr_en && addr == IFSB_ADDR_FLAG1 + 4'(i)) begin
        flag_nxt[i] = wdata;
      end
      flag_nxt[i] = (flag_nxt[i] | evt[i]) & impl[i];
    end

    // Flags latch requests whatever the enable says
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        flag_r[i] <= IFSB_FLAG_RST;
      end else begin
        flag_r[i] <= flag_nxt[i];
      end
    end

    // Enables share the flag layout; dead bits stay zero
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        en_r[i] <= IFSB_EN_RST;
      end else if (wr_en && addr == IFSB_ADDR_EN1 + 4'(i)) begin
        en_r[i] <= wdata & impl[i];
      end
    end

    // Per-register event summaries
    assign new_hit[i] = |(evt[i] & ~flag_r[i] & impl[i]);
    assign ovr_hit[i] = |(evt[i] & flag_r[i] & impl[i]);
    assign req_hit[i] = |(flag_r[i] & en_r[i]);
  end

  // Named flag positions, register one
  // positions 15..9 carry the upper-byte sources
  // positions 4..0 carry the lower sources, 8..5 masked off
  // register two positions 13, 9, 7..5, 1, 0
  // register three positions 14, 2, 1
  // register four positions 8, 3, 2, 1

  // Request to the CPU only through an enabled pending flag
  assign cpu_req = |req_hit;

  // Block status: new request taken, or event on an already pending flag
  always_comb begin
    stat_nxt = stat_r;
    if (wr_en && addr == IFSB_ADDR_STAT) begin
      stat_nxt = stat_r & ~wdata[1:0];
    end
    stat_nxt[IFSB_STAT_NEW_POS] = stat_nxt[IFSB_STAT_NEW_POS] | (|new_hit);
    stat_nxt[IFSB_STAT_OVR_POS] = stat_nxt[IFSB_STAT_OVR_POS] | (|ovr_hit);
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_r <= IFSB_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mask_r <= IFSB_MASK_RST;
    end else if (wr_en && addr == IFSB_ADDR_MASK) begin
      mask_r <= wdata[1:0];
    end
  end

  // Level interrupt straight from registers, no extra lag
  assign irq = |(stat_r & mask_r);

  // Read multiplexer; unmapped addresses return zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (addr)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        rdata_nxt = flag_r[addr[1:0]] & impl[addr[1:0]];
      end
      4'h4, 4'h5, 4'h6, 4'h7: begin
        rdata_nxt = en_r[addr[1:0]];
      end
      IFSB_ADDR_STAT: begin
        rdata_nxt = {14'h0, stat_r};
      end
      IFSB_ADDR_MASK: begin
        rdata_nxt = {14'h0, mask_r};
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Upper-byte sources of register one latch one cycle later
  uart_b_tx_a: assert property (
    evt_one[IFSB_UART_B_TX_POS] |=> flag_r[0][IFSB_UART_B_TX_POS])
    else $error("uart B tx event not latched");

  compare_three_a: assert property (
    evt_one[IFSB_COMPARE_THREE_POS] ##1 !wr_en [*2]
      |-> flag_r[0][IFSB_COMPARE_THREE_POS])
    else $error("compare three flag dropped without a write");

  // Register one read never shows bits 8..5
  reg_one_gap_a: assert property (
    rd_en && addr == IFSB_ADDR_FLAG1
      |=> rdata[8:5] == 4'h0)
    else $error("register one gap bits read nonzero");

  ext_irq_a_a: assert property (
    evt_one[IFSB_EXT_IRQ_A_POS] ##1 !wr_en
      ##1 (rd_en && addr == IFSB_ADDR_FLAG1)
      |=> rdata[IFSB_EXT_IRQ_A_POS])
    else $error("ext irq A flag not visible on read");

  spi_b_fault_a: assert property (
    evt_two[IFSB_SPI_B_FAULT_POS] |=> flag_r[1][IFSB_SPI_B_FAULT_POS])
    else $error("spi B fault event not latched");

  reg_two_gap_a: assert property (
    rd_en && addr == IFSB_ADDR_FLAG2
      |=> (rdata & ~IFSB_IMPL2) == 16'h0000)
    else $error("register two unused bits read nonzero");

  calendar_flag_a: assert property (
    evt_three[IFSB_CALENDAR_POS] |=> flag_r[2][IFSB_CALENDAR_POS])
    else $error("calendar event not latched");

  reg_three_gap_a: assert property (
    rd_en && addr == IFSB_ADDR_FLAG3
      |=> (rdata & ~IFSB_IMPL3) == 16'h0000)
    else $error("register three unused bits read nonzero");

  reg_four_read_a: assert property (
    evt_four[IFSB_LOW_VOLTAGE_POS] ##1 !wr_en
      ##1 (rd_en && addr == IFSB_ADDR_FLAG4)
      |=> rdata[IFSB_LOW_VOLTAGE_POS] && rdata[15:9] == 7'h00)
    else $error("register four low voltage read wrong");

  // A flag only rises through its event or a software write
  flag_cause_a: assert property (
    $rose(flag_r[0][IFSB_TIMER_FOUR_POS])
      |-> $past(evt_one[IFSB_TIMER_FOUR_POS])
          || $past(wr_en && addr == IFSB_ADDR_FLAG1))
    else $error("timer four flag rose without cause");

  // Reset clears flag registers one and four on the next edge
  reset_clear_a: assert property (
    disable iff (1'b0)
    !rstn |=> flag_r[0] == 16'h0000 && flag_r[3] == 16'h0000)
    else $error("flags not cleared by reset");

  sw_write_a: assert property (
    wr_en && addr == IFSB_ADDR_FLAG3 && evt_three == 16'h0000
      |=> flag_r[2] == (($past(wdata)) & IFSB_IMPL3))
    else $error("register three write not stored");

  unimpl_zero_a: assert property (
    (flag_r[0] & ~IFSB_IMPL1) == 16'h0000
      && (flag_r[3] & ~IFSB_IMPL4) == 16'h0000)
    else $error("unimplemented flag bit set");

  // An enabled pending flag raises the request
  enable_gate_a: assert property (
    flag_r[1][IFSB_PARALLEL_PORT_POS] && en_r[1][IFSB_PARALLEL_PORT_POS]
      |-> cpu_req)
    else $error("enabled pending flag raised no cpu request");

  // Event in the clearing write cycle still sets the flag
  set_wins_a: assert property (
    wr_en && addr == IFSB_ADDR_FLAG4 && !wdata[IFSB_CHECKSUM_GEN_POS]
      && evt_four[IFSB_CHECKSUM_GEN_POS]
      |=> flag_r[3][IFSB_CHECKSUM_GEN_POS])
    else $error("event lost against clearing write");

  disabled_set_a: assert property (
    evt_two[IFSB_PARALLEL_PORT_POS] && !en_r[1][IFSB_PARALLEL_PORT_POS]
      |=> flag_r[1][IFSB_PARALLEL_PORT_POS])
    else $error("disabled source flag not set");

  irq_level_a: assert property (
    stat_r[IFSB_STAT_NEW_POS] && mask_r[IFSB_STAT_NEW_POS] |-> irq)
    else $error("interrupt low with unmasked status");

  // Every implemented event lands, whatever else the cycle holds
  reg_one_latch_a: assert property (
    |(evt_one & IFSB_IMPL1)
      |=> (flag_r[0] & $past(evt_one & IFSB_IMPL1))
          == $past(evt_one & IFSB_IMPL1))
    else $error("register one event not latched");

  reg_two_latch_a: assert property (
    |(evt_two & IFSB_IMPL2)
      |=> (flag_r[1] & $past(evt_two & IFSB_IMPL2))
          == $past(evt_two & IFSB_IMPL2))
    else $error("register two event not latched");

  reg_three_latch_a: assert property (
    |(evt_three & IFSB_IMPL3)
      |=> (flag_r[2] & $past(evt_three & IFSB_IMPL3))
          == $past(evt_three & IFSB_IMPL3))
    else $error("register three event not latched");

  reg_four_latch_a: assert property (
    |(evt_four & IFSB_IMPL4)
      |=> (flag_r[3] & $past(evt_four & IFSB_IMPL4))
          == $past(evt_four & IFSB_IMPL4))
    else $error("register four event not latched");

  timer_five_a: assert property (
    evt_one[IFSB_TIMER_FIVE_POS] |=> flag_r[0][IFSB_TIMER_FIVE_POS])
    else $error("timer five event not latched");

  i2c_b_slave_a: assert property (
    evt_three[IFSB_I2C_B_SLAVE_POS] |=> flag_r[2][IFSB_I2C_B_SLAVE_POS])
    else $error("i2c B slave event not latched");

  uart_a_error_a: assert property (
    evt_four[IFSB_UART_A_ERROR_POS] |=> flag_r[3][IFSB_UART_A_ERROR_POS])
    else $error("uart A error event not latched");

  reg_four_gap_a: assert property (
    rd_en && addr == IFSB_ADDR_FLAG4
      |=> (rdata & ~IFSB_IMPL4) == 16'h0000)
    else $error("register four unused bits read nonzero");

  unimpl_mid_a: assert property (
    (flag_r[1] & ~IFSB_IMPL2) == 16'h0000
      && (flag_r[2] & ~IFSB_IMPL3) == 16'h0000)
    else $error("unimplemented flag bit set in register two or three");

  // No enable anywhere means no request, whatever is pending
  quiet_req_a: assert property (
    (en_r[0] | en_r[1] | en_r[2] | en_r[3]) == 16'h0000 |-> !cpu_req)
    else $error("cpu request without any enable");

  // Pending flag survives until software writes its register
  flag_hold_a: assert property (
    flag_r[2][IFSB_CALENDAR_POS] && !(wr_en && addr == IFSB_ADDR_FLAG3)
      |=> flag_r[2][IFSB_CALENDAR_POS])
    else $error("calendar flag dropped without a write");

  // Read data stands only in the cycle after a read strobe
  read_idle_a: assert property (
    !rd_en |=> rdata == 16'h0000)
    else $error("read data present without a read");

  // Main scenarios
  cov_req_c: cover property (
    evt_one[IFSB_UART_B_RX_POS] ##1 cpu_req);
  cov_clear_c: cover property (
    flag_r[2][IFSB_I2C_B_MASTER_POS] ##1
    (wr_en && addr == IFSB_ADDR_FLAG3) ##1
    !flag_r[2][IFSB_I2C_B_MASTER_POS]);
  cov_overrun_c: cover property (
    stat_r[IFSB_STAT_OVR_POS] && irq);
  cov_collide_c: cover property (
    wr_en && addr == IFSB_ADDR_FLAG4 && evt_four[IFSB_UART_A_ERROR_POS]);
  cov_read_c: cover property (
    rd_en && addr == IFSB_ADDR_FLAG2 ##1 rdata != 16'h0000);

endmodule

`default_nettype wire

// >>> dv/ifsb_evt_src.sv
// Event source model: the peripherals that raise interrupt requests.
// Assumes the bench holds go for exactly one clock cycle; sel and pat count only while go is high.
`default_nettype none

module ifsb_evt_src (
  input  wire logic        go,        // Fire request from the bench
  input  wire logic [1:0]  sel,       // Register lane, 0 is register one
  input  wire logic [15:0] pat,       // Bits to pulse on that lane
  output logic      [15:0] evt_one,   // Pulses, register one
  output logic      [15:0] evt_two,   // Pulses, register two
  output logic      [15:0] evt_three, // Pulses, register three
  output logic      [15:0] evt_four   // Pulses, register four
);
  timeunit 1ns;
  timeprecision 1ps;

  // One lane pulses per request; idle lanes stay low like quiet sources
  assign evt_one   = (go && sel == 2'h0) ? pat : 16'h0000;
  assign evt_two   = (go && sel == 2'h1) ? pat : 16'h0000;
  assign evt_three = (go && sel == 2'h2) ? pat : 16'h0000;
  assign evt_four  = (go && sel == 2'h3) ? pat : 16'h0000;
endmodule

`default_nettype wire

// >>> dv/ifsb_bank_bench.sv
// Self-checking bench for the interrupt flag status bank.
// Assumes the event source model ifsb_evt_src and one 100 MHz clock.
`default_nettype none

module ifsb_bank_bench
  import ifsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        go      = 1'b0;
  logic [1:0]  sel     = 2'h0;
  logic [15:0] pat     = 16'h0000;
  logic [15:0] rdata, rd_v;
  logic [15:0] evt_one, evt_two, evt_three, evt_four;
  logic        cpu_req, irq;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  // Implemented positions, worked out bit by bit from the flag layout
  logic [15:0] impl [4] = '{16'hfe1f, 16'h22e3, 16'h4006, 16'h010e};

  always #5 clk_sys = ~clk_sys;

  ifsb_bank dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .evt_one(evt_one), .evt_two(evt_two), .evt_three(evt_three),
    .evt_four(evt_four), .cpu_req(cpu_req), .irq(irq));
  ifsb_evt_src src (.go(go), .sel(sel), .pat(pat), .evt_one(evt_one),
    .evt_two(evt_two), .evt_three(evt_three), .evt_four(evt_four));

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus cycles: one-cycle strobes, released right after the taking edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    rd_v = rdata;
  endtask

  task automatic fire(input logic [1:0] s, input logic [15:0] p);
    @(posedge clk_sys);
    go  <= 1'b1;
    sel <= s;
    pat <= p;
    @(posedge clk_sys);
    go  <= 1'b0;
    #1;
  endtask

  // Everything clear after reset, read data drops after its cycle
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(IFSB_ADDR_FLAG1 + 4'(i));
      check("flag reset", rd_v, 16'h0000);
      rd(IFSB_ADDR_EN1 + 4'(i));
      check("enable reset", rd_v, 16'h0000);
    end
    rd(IFSB_ADDR_STAT);
    check("status reset", rd_v, 16'h0000);
    rd(IFSB_ADDR_MASK);
    check("mask reset", rd_v, 16'h0000);
    @(posedge clk_sys);
    #1;
    check("rdata idle", rdata, 16'h0000);
    check("outputs reset", {14'h0, cpu_req, irq}, 16'h0000);
  endtask

  // Software writes: only implemented bits stick; unmapped place is inert
  task automatic t_sw_rw();
    for (int i = 0; i < 4; i++) begin
      wr(IFSB_ADDR_FLAG1 + 4'(i), 16'hffff);
      rd(IFSB_ADDR_FLAG1 + 4'(i));
      check("flag all ones", rd_v, impl[i]);
      wr(IFSB_ADDR_FLAG1 + 4'(i), 16'h0000);
      rd(IFSB_ADDR_FLAG1 + 4'(i));
      check("flag cleared", rd_v, 16'h0000);
    end
    wr(4'ha, 16'hffff);
    rd(4'ha);
    check("unmapped", rd_v, 16'h0000);
  endtask

  // Every event lane, one bit at a time, lands only where a flag lives
  task automatic t_each_bit();
    logic [15:0] e;
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 16; b++) begin
        e = (16'h0001 << b) & impl[r];
        fire(2'(r), 16'h0001 << b);
        rd(IFSB_ADDR_FLAG1 + 4'(r));
        case (r)
          0: check("reg one bit", rd_v, e);
          1: check("reg two bit", rd_v, e);
          2: check("reg three bit", rd_v, e);
          default: check("reg four bit", rd_v, e);
        endcase
        wr(IFSB_ADDR_FLAG1 + 4'(r), 16'h0000);
      end
    end
  endtask

  // Flags set while disabled, request only once enabled, hold until cleared
  task automatic t_enable();
    for (int r = 0; r < 4; r++) begin
      fire(2'(r), 16'hffff);
      check("req disabled", {15'h0, cpu_req}, 16'h0000);
      wr(IFSB_ADDR_EN1 + 4'(r), 16'hffff);
      check("req enabled", {15'h0, cpu_req}, 16'h0001);
      rd(IFSB_ADDR_FLAG1 + 4'(r));
      check("flag held", rd_v, impl[r]);
      wr(IFSB_ADDR_FLAG1 + 4'(r), 16'h0000);
      check("req after clear", {15'h0, cpu_req}, 16'h0000);
      wr(IFSB_ADDR_EN1 + 4'(r), 16'h0000);
    end
  endtask

  // Clearing write and events in one cycle: the events must win
  task automatic t_collide();
    wr(IFSB_ADDR_FLAG4, 16'h0008);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr  <= IFSB_ADDR_FLAG4;
    wdata <= 16'h0000;
    go    <= 1'b1;
    sel   <= 2'h3;
    pat   <= 16'h000a;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    go    <= 1'b0;
    #1;
    rd(IFSB_ADDR_FLAG4);
    check("set beats clear", rd_v, 16'h000a);
    rd(IFSB_ADDR_STAT);
    check("status collide", rd_v, 16'h0003);
    wr(IFSB_ADDR_FLAG4, 16'h0000);
  endtask

  // Block interrupt: status set, masked, overrun, write-one clear
  task automatic t_irq();
    wr(IFSB_ADDR_STAT, 16'h0003);
    fire(2'h1, 16'h2000);
    rd(IFSB_ADDR_STAT);
    check("status new", rd_v, 16'h0001);
    check("irq masked", {15'h0, irq}, 16'h0000);
    wr(IFSB_ADDR_MASK, 16'h0001);
    check("irq unmasked", {15'h0, irq}, 16'h0001);
    fire(2'h1, 16'h2000);
    wr(IFSB_ADDR_STAT, 16'h0001);
    rd(IFSB_ADDR_STAT);
    check("status overrun", rd_v, 16'h0002);
    check("irq after clear", {15'h0, irq}, 16'h0000);
    wr(IFSB_ADDR_MASK, 16'h0002);
    check("irq overrun", {15'h0, irq}, 16'h0001);
    wr(IFSB_ADDR_STAT, 16'h0002);
    check("irq cleared", {15'h0, irq}, 16'h0000);
    wr(IFSB_ADDR_FLAG2, 16'h0000);
  endtask

  // A second reset in mid-run wipes pending flags
  task automatic t_midreset();
    wr(IFSB_ADDR_EN1 + 4'h2, 16'hffff);
    fire(2'h2, 16'h4006);
    check("req before reset", {15'h0, cpu_req}, 16'h0001);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    check("req in reset", {15'h0, cpu_req}, 16'h0000);
    rd(IFSB_ADDR_FLAG3);
    check("flag after reset", rd_v, 16'h0000);
    rd(IFSB_ADDR_EN1 + 4'h2);
    check("enable after reset", rd_v, 16'h0000);
    rd(IFSB_ADDR_STAT);
    check("status after reset", rd_v, 16'h0000);
    rd(IFSB_ADDR_MASK);
    check("mask after reset", rd_v, 16'h0000);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_sw_rw();
    t_each_bit();
    t_enable();
    t_collide();
    t_irq();
    t_midreset();
    close_out();
  end

  // Whole run needs about 540 cycles; this leaves wide margin
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule

`default_nettype wire
